/* File: rtl/alu_group_ctrl.sv */
// ALU instruction group control: forwarding, fp modes, flags and barrier
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "alu_ctrl_consts.svh"

// What this block does
// - Forward previous result on adjacent-group dependency
// - Predicated write: pick register or previous result
// - Check plain/loop write against plain/loop read
// - Check index write against same-index read
// - Single precision unless a double op
// - Double add, multiply, multiply-add round nearest
// - Double op takes two or four slots
// - Double words paired in X,Y / Z,W, swapped
// - Barrier parks waves until all arrive
// - Default modes from program resource config
// - Override holds until next or clause end
// - Override replaces all mode settings at once
// - Four round modes, four denormal switches
// - Six flags per work-item, slots combined
// - Flag bits: inexact down to invalid
// - Flags cleared at clause start
// - Flags accumulate by OR
// - Flag store writes flags to destination
// - Flag exchange writes then loads flags
// - Results go to previous-result and destination
// - Disabled lane writes nothing anywhere
module alu_group_ctrl #(
    parameter int LANES = 4,
    parameter int WAVES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire alu_ctrl_pkg::group_t grp_i,
    input wire alu_ctrl_pkg::slot_desc_t [3:0] slot_i,
    input wire logic [LANES-1:0] pred_i,
    input wire logic [`GPR_AW-1:0] loop_idx_i,
    input wire logic [`GPR_AW-1:0] gpr_idx_i,
    input wire logic [4*LANES*`DATA_W-1:0] gpr_rd_i,
    input wire logic [4*LANES*`DATA_W-1:0] res_i,
    input wire logic [4*LANES*`FLAG_W-1:0] exc_i,
    input wire logic [WAVES-1:0] barrier_i,
    input wire logic [`REG_AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [4*LANES*`DATA_W-1:0] opnd_o,
    output logic [3:0] fwd_o,
    output logic [4*LANES-1:0] gpr_we_o,
    output logic [4*`GPR_AW-1:0] gpr_waddr_o,
    output logic [4*LANES*`DATA_W-1:0] gpr_wdata_o,
    output alu_ctrl_pkg::fp_mode_t [3:0] slot_mode_o,
    output logic [3:0] dp_o,
    output logic [LANES*`FLAG_W-1:0] flags_o,
    output logic [WAVES-1:0] wave_active_o
);
    localparam int SLOTS = 4;
    localparam int DW = `DATA_W;
    localparam int FW = `FLAG_W;
    localparam int AW = `GPR_AW;
    localparam int ND = SLOTS * LANES * DW;

    if (LANES < 1 || LANES * FW > 32 || WAVES < 1 || WAVES > `WAVE_HI_LSB) begin : g_chk
        $error("alu_group_ctrl: LANES or WAVES out of range");
    end

    typedef struct packed {
        logic [ND-1:0] pv;
        logic [SLOTS*AW-1:0] prev_addr;
        logic [SLOTS*2-1:0] prev_am;
        logic [SLOTS-1:0] prev_wv;
        logic [SLOTS*LANES-1:0] prev_exec;
        alu_ctrl_pkg::fp_mode_t def_mode;
        alu_ctrl_pkg::fp_mode_t cur_mode;
        logic [LANES*FW-1:0] flags;
        logic [WAVES-1:0] arrived;
        logic [WAVES-1:0] active;
        logic [ND-1:0] opnd;
        logic [ND-1:0] wdata;
        logic [SLOTS-1:0] fwd;
        logic [SLOTS-1:0] dp;
        logic [SLOTS*LANES-1:0] we;
        logic [SLOTS*AW-1:0] waddr;
        alu_ctrl_pkg::fp_mode_t [SLOTS-1:0] emode;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    alu_ctrl_pkg::fp_mode_t grp_mode;
    logic [SLOTS*LANES-1:0] exec;
    logic [SLOTS-1:0] dpm;
    logic [SLOTS-1:0] hit;
    logic [LANES*FW-1:0] flags_cur;
    logic [LANES*FW-1:0] acc;
    logic [WAVES-1:0] arr;
    logic [AW-1:0] src_ea;
    logic [DW-1:0] res_w;
    logic xchg_any;

    function automatic logic [AW-1:0] eff_addr(input logic [AW-1:0] base,
                                               input alu_ctrl_pkg::addr_mode_t am,
                                               input logic [AW-1:0] lidx,
                                               input logic [AW-1:0] gidx);
        logic [AW-1:0] r;
        r = base;
        if (am == alu_ctrl_pkg::AM_LOOP) begin
            r = base + lidx;
        end else if (am == alu_ctrl_pkg::AM_GIDX) begin
            r = base + gidx;
        end
        return r;
    endfunction : eff_addr

    always_comb begin
        s_d = s_q;
        exec = '0;
        dpm = '0;
        hit = '0;
        xchg_any = 1'b0;
        src_ea = '0;
        res_w = '0;
        // Default modes from program resource config at clause start
        // default mode source
        grp_mode = grp_i.clause_start ? s_q.def_mode : s_q.cur_mode;
        flags_cur = grp_i.clause_start ? '0 : s_q.flags;
        acc = flags_cur;
        for (int s = 0; s < SLOTS; s++) begin
            if (grp_i.valid && slot_i[s].op == alu_ctrl_pkg::OPK_SET_MODE) begin
                grp_mode = slot_i[s].mode_val;
            end
            if (grp_i.valid && (slot_i[s].op == alu_ctrl_pkg::OPK_DP_BASIC ||
                                slot_i[s].op == alu_ctrl_pkg::OPK_DP_OTHER)) begin
                if (slot_i[s].dp_four) begin
                    dpm = '1;
                end else begin
                    dpm[s] = 1'b1;
                    dpm[s ^ 1] = 1'b1;
                end
            end
            if (grp_i.valid && slot_i[s].op == alu_ctrl_pkg::OPK_FLAG_XCHG) begin
                xchg_any = 1'b1;
            end
            for (int l = 0; l < LANES; l++) begin
                exec[s*LANES+l] = grp_i.valid && slot_i[s].op != alu_ctrl_pkg::OPK_NOP &&
                    slot_i[s].op != alu_ctrl_pkg::OPK_BARRIER &&
                    (slot_i[s].pred_sel == alu_ctrl_pkg::PS_OFF ||
                     (slot_i[s].pred_sel == alu_ctrl_pkg::PS_ZERO && !pred_i[l]) ||
                     (slot_i[s].pred_sel == alu_ctrl_pkg::PS_ONE && pred_i[l]));
            end
        end
        for (int s = 0; s < SLOTS; s++) begin
            src_ea = eff_addr(slot_i[s].src_base, slot_i[s].src_mode, loop_idx_i, gpr_idx_i);
            hit[s] = grp_i.valid && !grp_i.clause_start && s_q.prev_wv[s] &&
                src_ea == s_q.prev_addr[s*AW +: AW] &&
                (((s_q.prev_am[s*2 +: 2] != alu_ctrl_pkg::AM_GIDX) &&
                  (slot_i[s].src_mode != alu_ctrl_pkg::AM_GIDX)) ||
                 ((s_q.prev_am[s*2 +: 2] == alu_ctrl_pkg::AM_GIDX) &&
                  (slot_i[s].src_mode == alu_ctrl_pkg::AM_GIDX)));
            s_d.dp[s] = dpm[s];
            s_d.emode[s] = grp_mode;
            if (grp_i.valid && slot_i[s].op == alu_ctrl_pkg::OPK_DP_BASIC) begin
                s_d.emode[s].rnd = alu_ctrl_pkg::RND_NEAREST;
            end
            s_d.fwd[s] = hit[s];
            s_d.waddr[s*AW +: AW] = eff_addr(slot_i[s].dst_base, slot_i[s].dst_mode,
                                             loop_idx_i, gpr_idx_i);
            for (int l = 0; l < LANES; l++) begin
                if (hit[s] && s_q.prev_exec[s*LANES+l]) begin
                    s_d.opnd[(s*LANES+l)*DW +: DW] = s_q.pv[(s*LANES+l)*DW +: DW];
                end else begin
                    s_d.opnd[(s*LANES+l)*DW +: DW] = gpr_rd_i[(s*LANES+l)*DW +: DW];
                end
                if (dpm[s]) begin
                    res_w = res_i[((s ^ 1)*LANES+l)*DW +: DW];
                end else begin
                    res_w = res_i[(s*LANES+l)*DW +: DW];
                end
                if (slot_i[s].op == alu_ctrl_pkg::OPK_FLAG_STORE ||
                    slot_i[s].op == alu_ctrl_pkg::OPK_FLAG_XCHG) begin
                    res_w = {{(DW-FW){1'b0}}, flags_cur[l*FW +: FW]};
                end
                s_d.wdata[(s*LANES+l)*DW +: DW] = res_w;
                s_d.we[s*LANES+l] = exec[s*LANES+l] && slot_i[s].wr_en &&
                    slot_i[s].op != alu_ctrl_pkg::OPK_SET_MODE;
                if (exec[s*LANES+l]) begin
                    s_d.pv[(s*LANES+l)*DW +: DW] = res_w;
                end
                if (exec[s*LANES+l]) begin
                    acc[l*FW +: FW] = acc[l*FW +: FW] | exc_i[(s*LANES+l)*FW +: FW];
                end
            end
        end
        for (int s = 0; s < SLOTS; s++) begin
            for (int l = 0; l < LANES; l++) begin
                if (exec[s*LANES+l] && slot_i[s].op == alu_ctrl_pkg::OPK_FLAG_XCHG) begin
                    acc[l*FW +: FW] = gpr_rd_i[(s*LANES+l)*DW +: FW];
                end
            end
        end
        if (grp_i.valid) begin
            for (int s = 0; s < SLOTS; s++) begin
                s_d.prev_wv[s] = slot_i[s].op != alu_ctrl_pkg::OPK_NOP &&
                    slot_i[s].op != alu_ctrl_pkg::OPK_BARRIER && slot_i[s].wr_en;
                s_d.prev_addr[s*AW +: AW] = s_d.waddr[s*AW +: AW];
                s_d.prev_am[s*2 +: 2] = slot_i[s].dst_mode;
            end
            s_d.prev_exec = exec;
            s_d.flags = acc;
            // hold until next or clause end
            s_d.cur_mode = grp_i.clause_end ? s_q.def_mode : grp_mode;
        end
        arr = s_q.arrived | barrier_i;
        if (arr == {WAVES{1'b1}}) begin
            s_d.arrived = '0;
            s_d.active = '1;
        end else begin
            s_d.arrived = arr;
            s_d.active = ~arr;
        end
        if (wr_i && addr_i == `REG_DEF_MODE) begin
            s_d.def_mode = wdata_i[$bits(alu_ctrl_pkg::fp_mode_t)-1:0];
        end
        s_d.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                `REG_DEF_MODE: s_d.rdata[$bits(alu_ctrl_pkg::fp_mode_t)-1:0] = s_q.def_mode;
                `REG_CUR_MODE: s_d.rdata[$bits(alu_ctrl_pkg::fp_mode_t)-1:0] = s_q.cur_mode;
                `REG_FLAGS: s_d.rdata[LANES*FW-1:0] = s_q.flags;
                `REG_WAVE: begin
                    s_d.rdata[WAVES-1:0] = s_q.arrived;
                    s_d.rdata[`WAVE_HI_LSB +: WAVES] = s_q.active;
                end
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.active <= '1;
            s_q.def_mode <= `DEF_MODE_RST;
            s_q.cur_mode <= `DEF_MODE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign opnd_o = s_q.opnd;
    assign fwd_o = s_q.fwd;
    assign gpr_we_o = s_q.we;
    assign gpr_waddr_o = s_q.waddr;
    assign gpr_wdata_o = s_q.wdata;
    assign slot_mode_o = s_q.emode;
    assign dp_o = s_q.dp;
    assign flags_o = s_q.flags;
    assign wave_active_o = s_q.active;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_fwd_pv_value: assert property (
        grp_i.valid && !grp_i.clause_start && s_q.prev_wv[0] && s_q.prev_exec[0] &&
        slot_i[0].src_mode == alu_ctrl_pkg::AM_PLAIN &&
        s_q.prev_am[1:0] == alu_ctrl_pkg::AM_PLAIN &&
        slot_i[0].src_base == s_q.prev_addr[AW-1:0]
        |=> fwd_o[0] && opnd_o[DW-1:0] == $past(s_q.pv[DW-1:0]))
        else $error("forwarded operand is not the previous result");
    a_pred_reg_pick: assert property (
        grp_i.valid && !(hit[0] && s_q.prev_exec[0])
        |=> opnd_o[DW-1:0] == $past(gpr_rd_i[DW-1:0]))
        else $error("operand without dependency not taken from register");
    a_dp_round_near: assert property (
        grp_i.valid && slot_i[0].op == alu_ctrl_pkg::OPK_DP_BASIC
        |=> slot_mode_o[0].rnd == alu_ctrl_pkg::RND_NEAREST && dp_o[0] && dp_o[1])
        else $error("double op not nearest or not paired");
    a_mode_restore: assert property (
        grp_i.valid && grp_i.clause_end |=> s_q.cur_mode == $past(s_q.def_mode))
        else $error("mode not restored at clause end");
    a_mode_whole: assert property (
        grp_i.valid && !grp_i.clause_end && slot_i[3].op == alu_ctrl_pkg::OPK_SET_MODE &&
        slot_i[0].op != alu_ctrl_pkg::OPK_DP_BASIC
        |=> s_q.cur_mode == $past(slot_i[3].mode_val) && slot_mode_o[0] == s_q.cur_mode)
        else $error("mode override not applied whole");
    a_flag_clear: assert property (
        grp_i.valid && grp_i.clause_start && exc_i == '0 && !xchg_any |=> flags_o == '0)
        else $error("flags not cleared at clause start");
    a_flag_sticky: assert property (
        grp_i.valid && !grp_i.clause_start && !xchg_any
        |=> (flags_o & $past(flags_o)) == $past(flags_o))
        else $error("accumulated flag was lost");
    a_pred_no_write: assert property (
        grp_i.valid && slot_i[0].pred_sel == alu_ctrl_pkg::PS_ONE && !pred_i[0]
        |=> !gpr_we_o[0] && s_q.pv[DW-1:0] == $past(s_q.pv[DW-1:0]))
        else $error("disabled lane wrote a result");
    a_barrier_hold: assert property (
        (s_q.arrived | barrier_i) != {WAVES{1'b1}} && barrier_i != '0
        |=> wave_active_o != {WAVES{1'b1}} ##1 1'b1)
        else $error("wave released before all arrived");
    a_barrier_free: assert property (
        (s_q.arrived | barrier_i) == {WAVES{1'b1}}
        |=> wave_active_o == {WAVES{1'b1}} && s_q.arrived == '0)
        else $error("waves not released together");
    a_fwd_index_pair: assert property (
        grp_i.valid && !grp_i.clause_start && s_q.prev_wv[0] && s_q.prev_exec[0] &&
        slot_i[0].src_mode == alu_ctrl_pkg::AM_GIDX &&
        s_q.prev_am[1:0] == alu_ctrl_pkg::AM_GIDX &&
        AW'(slot_i[0].src_base + gpr_idx_i) == s_q.prev_addr[AW-1:0]
        |=> fwd_o[0] && opnd_o[DW-1:0] == $past(s_q.pv[DW-1:0]))
        else $error("index pair not forwarded");
    a_dp_swap: assert property (
        grp_i.valid && slot_i[0].op == alu_ctrl_pkg::OPK_DP_OTHER
        |=> dp_o[1] && gpr_wdata_o[DW-1:0] == $past(res_i[LANES*DW +: DW]))
        else $error("double result words not swapped");
    a_flag_out: assert property (
        grp_i.valid && !grp_i.clause_start &&
        (slot_i[0].op == alu_ctrl_pkg::OPK_FLAG_STORE ||
         slot_i[0].op == alu_ctrl_pkg::OPK_FLAG_XCHG)
        |=> gpr_wdata_o[FW-1:0] == $past(s_q.flags[FW-1:0]))
        else $error("flag store did not write the flags");
    a_dest_write: assert property (
        grp_i.valid && exec[0] && slot_i[0].wr_en && !dpm[0] &&
        slot_i[0].op == alu_ctrl_pkg::OPK_NORM &&
        slot_i[0].dst_mode == alu_ctrl_pkg::AM_PLAIN
        |=> gpr_we_o[0] && gpr_waddr_o[AW-1:0] == $past(slot_i[0].dst_base) &&
            gpr_wdata_o[DW-1:0] == $past(res_i[DW-1:0]))
        else $error("result not written to destination");
    a_pv_follows: assert property (
        grp_i.valid && exec[0] |=> s_q.pv[DW-1:0] == gpr_wdata_o[DW-1:0])
        else $error("previous result not kept");
    a_flag_combine: assert property (
        grp_i.valid && !grp_i.clause_start && !xchg_any && exec[0]
        |=> (flags_o[FW-1:0] & $past(exc_i[FW-1:0])) == $past(exc_i[FW-1:0]))
        else $error("work-item flags missed a slot");
    a_clause_default: assert property (
        grp_i.valid && grp_i.clause_start &&
        slot_i[1].op != alu_ctrl_pkg::OPK_DP_BASIC &&
        slot_i[0].op != alu_ctrl_pkg::OPK_SET_MODE &&
        slot_i[1].op != alu_ctrl_pkg::OPK_SET_MODE &&
        slot_i[2].op != alu_ctrl_pkg::OPK_SET_MODE &&
        slot_i[3].op != alu_ctrl_pkg::OPK_SET_MODE
        |=> slot_mode_o[1] == $past(s_q.def_mode))
        else $error("clause did not start in default mode");
endmodule : alu_group_ctrl

/* File: rtl/alu_ctrl_consts.svh */
// Constants for the ALU group control block: widths, offsets, reset values
`ifndef ALU_CTRL_CONSTS_SVH
`define ALU_CTRL_CONSTS_SVH
`define GPR_AW 7
`define DATA_W 32
`define FLAG_W 6
`define FLG_INVALID 0
`define FLG_DENORM 1
`define FLG_DIVZERO 2
`define FLG_OVERFLOW 3
`define FLG_UNDERFLOW 4
`define FLG_INEXACT 5
`define REG_AW 4
`define REG_DEF_MODE 4'h0
`define REG_CUR_MODE 4'h4
`define REG_FLAGS 4'h8
`define REG_WAVE 4'hc
`define DEF_MODE_RST 6'h00
`define WAVE_HI_LSB 16
`endif

/* File: rtl/alu_ctrl_pkg.sv */
// Types shared by the ALU group control block and its environment
`include "alu_ctrl_consts.svh"
package alu_ctrl_pkg;
    typedef enum logic [2:0] {
        OPK_NORM = 3'h0,
        OPK_DP_BASIC = 3'h1,
        OPK_DP_OTHER = 3'h2,
        OPK_SET_MODE = 3'h3,
        OPK_FLAG_STORE = 3'h4,
        OPK_FLAG_XCHG = 3'h5,
        OPK_NOP = 3'h6,
        OPK_BARRIER = 3'h7
    } op_kind_t;
    typedef enum logic [1:0] {
        AM_PLAIN = 2'h0,
        AM_LOOP = 2'h1,
        AM_GIDX = 2'h2
    } addr_mode_t;
    typedef enum logic [1:0] {
        PS_OFF = 2'h0,
        PS_ZERO = 2'h1,
        PS_ONE = 2'h2
    } pred_sel_t;
    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_ZERO = 2'h1,
        RND_PINF = 2'h2,
        RND_NINF = 2'h3
    } round_t;
    typedef struct packed {
        round_t rnd;
        logic sp_flush;
        logic sp_ftz;
        logic dp_flush;
        logic dp_ftz;
    } fp_mode_t;
    typedef struct packed {
        op_kind_t op;
        logic dp_four;
        logic [`GPR_AW-1:0] src_base;
        addr_mode_t src_mode;
        logic [`GPR_AW-1:0] dst_base;
        addr_mode_t dst_mode;
        logic wr_en;
        pred_sel_t pred_sel;
        fp_mode_t mode_val;
    } slot_desc_t;
    typedef struct packed {
        logic valid;
        logic clause_start;
        logic clause_end;
    } group_t;
endpackage : alu_ctrl_pkg

/* File: verification/group_issuer.sv */
// Sequencer model that issues ALU instruction groups to the control block
`timescale 1ns/10ps
`include "alu_ctrl_consts.svh"
module group_issuer (
    input wire logic clk_i,
    output alu_ctrl_pkg::group_t grp_o,
    output alu_ctrl_pkg::slot_desc_t [3:0] slot_o,
    output logic [3:0] pred_o,
    output logic [`GPR_AW-1:0] loop_idx_o,
    output logic [`GPR_AW-1:0] gpr_idx_o
);
    logic gidx_wr_q;
    initial begin
        grp_o = '0;
        slot_o = '0;
        pred_o = '0;
        loop_idx_o = '0;
        gpr_idx_o = '0;
        gidx_wr_q = 1'b0;
    end
    // Called just after a rising edge; the group stands for one cycle
    task automatic issue(input alu_ctrl_pkg::group_t g, input alu_ctrl_pkg::slot_desc_t [3:0] s,
            input logic [3:0] p, input logic [`GPR_AW-1:0] li, input logic [`GPR_AW-1:0] gi);
        alu_ctrl_pkg::slot_desc_t nop_s;
        nop_s = '0;
        nop_s.op = alu_ctrl_pkg::OPK_NOP;
        if (gidx_wr_q && s[0].src_mode != alu_ctrl_pkg::AM_GIDX) begin
            grp_o <= alu_ctrl_pkg::group_t'(3'b100);
            slot_o <= {4{nop_s}};
            @(posedge clk_i);
        end
        grp_o <= g;
        slot_o <= s;
        pred_o <= p;
        loop_idx_o <= li;
        gpr_idx_o <= gi;
        gidx_wr_q = (s[0].dst_mode == alu_ctrl_pkg::AM_GIDX);
        @(posedge clk_i);
        grp_o <= '0;
        // Released slot and predicate fields do not keep their last value; the index fields do
        slot_o <= ~s;
        pred_o <= ~p;
    endtask : issue
endmodule : group_issuer

/* File: verification/test_alu_group_ctrl.sv */
// Self-checking bench for the ALU group control block
`timescale 1ns/10ps
`include "alu_ctrl_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_alu_group_ctrl;
    localparam int DW = 16 * `DATA_W;
    logic clk_i;
    logic rst_i;
    alu_ctrl_pkg::group_t grp;
    alu_ctrl_pkg::slot_desc_t [3:0] slot;
    logic [3:0] pred;
    logic [`GPR_AW-1:0] loop_idx;
    logic [`GPR_AW-1:0] gpr_idx;
    logic [DW-1:0] gpr_rd;
    logic [DW-1:0] res;
    logic [16*`FLAG_W-1:0] exc;
    logic [3:0] barrier;
    logic [`REG_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [DW-1:0] opnd;
    logic [3:0] fwd;
    logic [15:0] gpr_we;
    logic [4*`GPR_AW-1:0] gpr_waddr;
    logic [DW-1:0] gpr_wdata;
    alu_ctrl_pkg::fp_mode_t [3:0] slot_mode;
    logic [3:0] dp;
    logic [4*`FLAG_W-1:0] flags;
    logic [3:0] wave_active;
    int fail_count;
    int cmp_count;
    alu_ctrl_pkg::slot_desc_t [3:0] s;
    logic [DW-1:0] res_v;
    logic [DW-1:0] gpr_v;
    logic [16*`FLAG_W-1:0] exc_v;
    alu_ctrl_pkg::fp_mode_t m;

    group_issuer group_issuer_inst (.clk_i(clk_i), .grp_o(grp), .slot_o(slot), .pred_o(pred),
        .loop_idx_o(loop_idx), .gpr_idx_o(gpr_idx));
    alu_group_ctrl #(.LANES(4), .WAVES(4)) alu_group_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .grp_i(grp), .slot_i(slot), .pred_i(pred), .loop_idx_i(loop_idx), .gpr_idx_i(gpr_idx),
        .gpr_rd_i(gpr_rd), .res_i(res), .exc_i(exc), .barrier_i(barrier), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .opnd_o(opnd), .fwd_o(fwd),
        .gpr_we_o(gpr_we), .gpr_waddr_o(gpr_waddr), .gpr_wdata_o(gpr_wdata),
        .slot_mode_o(slot_mode), .dp_o(dp), .flags_o(flags), .wave_active_o(wave_active));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic alu_ctrl_pkg::slot_desc_t mk(input alu_ctrl_pkg::op_kind_t op,
            input logic [6:0] sb, input alu_ctrl_pkg::addr_mode_t sm, input logic [6:0] db,
            input alu_ctrl_pkg::addr_mode_t dm, input alu_ctrl_pkg::pred_sel_t ps);
        mk = '0;
        mk.op = op;
        mk.src_base = sb;
        mk.src_mode = sm;
        mk.dst_base = db;
        mk.dst_mode = dm;
        mk.pred_sel = ps;
        mk.wr_en = 1'b1;
    endfunction : mk

    // Word of slot s, lane l carries the tag byte and its own index
    function automatic logic [DW-1:0] pat(input logic [7:0] b);
        for (int i = 0; i < 16; i++) begin
            pat[i*32+:32] = {b, 24'(i)};
        end
    endfunction : pat

    task automatic fill(input alu_ctrl_pkg::op_kind_t op);
        s = {4{mk(op, 7'h0, alu_ctrl_pkg::AM_PLAIN, 7'h20, alu_ctrl_pkg::AM_PLAIN,
            alu_ctrl_pkg::PS_OFF)}};
    endtask : fill

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : reg_rd

    // Group outputs are settled just after the rising edge that takes the group
    task automatic run(input logic [2:0] g, input logic [3:0] p);
        @(posedge clk_i);
        res <= res_v;
        gpr_rd <= gpr_v;
        exc <= exc_v;
        group_issuer_inst.issue(alu_ctrl_pkg::group_t'(g), s, p, 7'h3, 7'h4);
        #1;
    endtask : run

    // Loop index is 3 and index register 4 in every group
    task automatic fwd_case(input logic [6:0] wb, input alu_ctrl_pkg::addr_mode_t wm,
            input logic [6:0] rb, input alu_ctrl_pkg::addr_mode_t rm, input logic e);
        fill(alu_ctrl_pkg::OPK_NOP);
        s[0] = mk(alu_ctrl_pkg::OPK_NORM, 7'h0, alu_ctrl_pkg::AM_PLAIN, wb, wm,
            alu_ctrl_pkg::PS_OFF);
        res_v = pat(8'ha1);
        run(3'b110, 4'hf);
        s[0] = mk(alu_ctrl_pkg::OPK_NORM, rb, rm, 7'h7f, alu_ctrl_pkg::AM_PLAIN,
            alu_ctrl_pkg::PS_OFF);
        res_v = pat(8'ha2);
        run(3'b100, 4'hf);
        `CHK(fwd[0], e)
        `CHK(opnd[31:0], e ? {8'ha1, 24'h0} : {8'hb0, 24'h0})
    endtask : fwd_case

    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end

    initial begin
        rst_i = 1'b1;
        barrier = '0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        res = '0;
        gpr_rd = '0;
        exc = '0;
        fail_count = 0;
        cmp_count = 0;
        exc_v = '0;
        res_v = '0;
        gpr_v = pat(8'hb0);
        s = '0;
        m = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK(wave_active, 4'hf)
        reg_rd(`REG_DEF_MODE, 32'h0);
        reg_rd(4'h2, 32'h0);
        reg_wr(`REG_DEF_MODE, 32'h2a);
        reg_wr(`REG_FLAGS, 32'h3f);
        reg_rd(`REG_DEF_MODE, 32'h2a);
        reg_rd(`REG_FLAGS, 32'h0);
        fwd_case(7'h01, alu_ctrl_pkg::AM_PLAIN, 7'h01, alu_ctrl_pkg::AM_PLAIN, 1'b1);
        `CHK(slot_mode[1], alu_ctrl_pkg::fp_mode_t'(6'h2a))
        fwd_case(7'h02, alu_ctrl_pkg::AM_LOOP, 7'h05, alu_ctrl_pkg::AM_PLAIN, 1'b1);
        fwd_case(7'h03, alu_ctrl_pkg::AM_PLAIN, 7'h00, alu_ctrl_pkg::AM_LOOP, 1'b1);
        fwd_case(7'h01, alu_ctrl_pkg::AM_PLAIN, 7'h02, alu_ctrl_pkg::AM_PLAIN, 1'b0);
        fwd_case(7'h01, alu_ctrl_pkg::AM_GIDX, 7'h01, alu_ctrl_pkg::AM_GIDX, 1'b1);
        fwd_case(7'h01, alu_ctrl_pkg::AM_GIDX, 7'h05, alu_ctrl_pkg::AM_PLAIN, 1'b0);
        // Predicated write only in lanes 1 and 3
        fill(alu_ctrl_pkg::OPK_NOP);
        s[0] = mk(alu_ctrl_pkg::OPK_NORM, 7'h0, alu_ctrl_pkg::AM_PLAIN, 7'h01,
            alu_ctrl_pkg::AM_PLAIN, alu_ctrl_pkg::PS_ONE);
        res_v = pat(8'ha7);
        run(3'b100, 4'b1010);
        `CHK(gpr_we[3:0], 4'b1010)
        `CHK(gpr_waddr[6:0], 7'h01)
        `CHK(gpr_wdata[63:32], {8'ha7, 24'h1})
        s[0] = mk(alu_ctrl_pkg::OPK_NORM, 7'h01, alu_ctrl_pkg::AM_PLAIN, 7'h7f,
            alu_ctrl_pkg::AM_PLAIN, alu_ctrl_pkg::PS_OFF);
        res_v = pat(8'ha8);
        run(3'b100, 4'hf);
        `CHK(opnd[63:0], {8'ha7, 24'h1, 8'hb0, 24'h0})
        `CHK(opnd[127:64], {8'ha7, 24'h3, 8'hb0, 24'h2})
        // Flags accumulate within a clause
        fill(alu_ctrl_pkg::OPK_NORM);
        exc_v[5:0] = 6'h01;
        exc_v[29:24] = 6'h20;
        run(3'b110, 4'hf);
        `CHK(flags[11:0], 12'h021)
        exc_v = '0;
        exc_v[5:0] = 6'h04;
        run(3'b100, 4'hf);
        `CHK(flags[5:0], 6'h25)
        reg_rd(`REG_FLAGS, 32'h25);
        exc_v = '0;
        s[0] = mk(alu_ctrl_pkg::OPK_FLAG_STORE, 7'h04, alu_ctrl_pkg::AM_PLAIN, 7'h03,
            alu_ctrl_pkg::AM_PLAIN, alu_ctrl_pkg::PS_OFF);
        run(3'b100, 4'hf);
        `CHK(gpr_wdata[5:0], 6'h25)
        s[0].op = alu_ctrl_pkg::OPK_FLAG_XCHG;
        gpr_v[5:0] = 6'h0a;
        run(3'b100, 4'hf);
        `CHK(gpr_wdata[5:0], 6'h25)
        `CHK(flags[5:0], 6'h0a)
        gpr_v = pat(8'hb0);
        fill(alu_ctrl_pkg::OPK_NORM);
        run(3'b110, 4'hf);
        `CHK(flags[5:0], 6'h00)
        // Every round mode through an override in slot 3
        for (int r = 0; r < 4; r++) begin
            fill(alu_ctrl_pkg::OPK_NORM);
            s[3] = mk(alu_ctrl_pkg::OPK_SET_MODE, 7'h0, alu_ctrl_pkg::AM_PLAIN, 7'h21,
                alu_ctrl_pkg::AM_PLAIN, alu_ctrl_pkg::PS_OFF);
            s[3].mode_val = alu_ctrl_pkg::fp_mode_t'({2'(r), 4'(4'h5 ^ r)});
            m = s[3].mode_val;
            run(3'b100, 4'hf);
            for (int k = 0; k < 3; k++) begin
                `CHK(slot_mode[k], m)
            end
        end
        reg_rd(`REG_CUR_MODE, 32'h36);
        fill(alu_ctrl_pkg::OPK_NORM);
        s[0].op = alu_ctrl_pkg::OPK_DP_OTHER;
        s[1].op = alu_ctrl_pkg::OPK_DP_OTHER;
        res_v = pat(8'hd0);
        run(3'b100, 4'hf);
        `CHK(dp, 4'b0011)
        `CHK(gpr_wdata[31:0], {8'hd0, 24'h4})
        `CHK(slot_mode[2], m)
        s[0].dp_four = 1'b1;
        run(3'b100, 4'hf);
        `CHK(dp, 4'hf)
        fill(alu_ctrl_pkg::OPK_NORM);
        s[0].op = alu_ctrl_pkg::OPK_DP_BASIC;
        s[1].op = alu_ctrl_pkg::OPK_DP_BASIC;
        run(3'b100, 4'hf);
        `CHK(slot_mode[0].rnd, alu_ctrl_pkg::RND_NEAREST)
        fill(alu_ctrl_pkg::OPK_NORM);
        run(3'b101, 4'hf);
        `CHK(slot_mode[2], m)
        run(3'b100, 4'hf);
        `CHK(slot_mode[2], alu_ctrl_pkg::fp_mode_t'(6'h2a))
        // Barrier: one wave parks, the rest arrive together
        @(posedge clk_i);
        barrier <= 4'b0001;
        @(posedge clk_i);
        barrier <= 4'b0000;
        #1;
        `CHK(wave_active, 4'b1110)
        reg_rd(`REG_WAVE, 32'h000e0001);
        @(posedge clk_i);
        barrier <= 4'b1110;
        @(posedge clk_i);
        barrier <= 4'b0000;
        #1;
        `CHK(wave_active, 4'hf)
        complete_run();
    end
endmodule : test_alu_group_ctrl
